// *** rtl/mpsc_pkg.sv ***
// Shared constants for the motor PWM and step control block.
// Assumes a 16-bit plain register port where each register has one word address.
package mpsc_pkg;

    // ==========================================================
    // Widths
    localparam int CNT_W   = 12;              // PWM counter and period width
    localparam int CMP_W   = 13;              // Channel compare width
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 16;
    localparam int NUM_CH  = 3;

    // ==========================================================
    // Register word addresses
    localparam logic [3:0] ADDR_PERIOD   = 4'h0;
    localparam logic [3:0] ADDR_CMP0     = 4'h1;   // Channels follow at 1, 2, 3
    localparam logic [3:0] ADDR_CTRL_B   = 4'h4;
    localparam logic [3:0] ADDR_PHASE    = 4'h5;
    localparam logic [3:0] ADDR_MISC     = 4'h6;
    localparam logic [3:0] ADDR_STATUS   = 4'h7;

    // ==========================================================
    // Control register B fields
    localparam int CB_EDGE   = 6;
    localparam int CB_HDM    = 5;
    localparam int CB_SDM    = 4;
    localparam int CB_OCV    = 3;
    localparam int CB_OS_CD  = 2;
    localparam int CB_OS_DZ  = 1;
    localparam int CB_OS_ZC  = 0;
    localparam logic [7:0] CB_RESET      = 8'h00;
    localparam logic [7:0] CB_WR_MASK    = 8'h7f;  // Top bit reserved
    localparam logic [7:0] CB_PRELOAD    = 8'h74;  // Edge, both demag, top mode bit

    // ==========================================================
    // Misc control fields
    localparam int MISC_DIRECT = 0;              // Direct access mode
    localparam int MISC_CURRENT_LIMIT_IRQ_MASK   = 1;              // Current limit interrupt mask
    localparam int MISC_MOE    = 2;              // Main output enable
    localparam logic [2:0] MISC_RESET = 3'h0;

    // ==========================================================
    // Status fields
    localparam int ST_CLI   = 0;                 // Current limit flag, write 1 clears
    localparam int ST_PHASE = 1;                 // Two bits: step interval

    // ==========================================================
    // Phase state register: high-side phase index [1:0], low-side index [3:2]
    localparam logic [3:0] PHASE_RESET = 4'h4;

    // Step interval within one commutation step
    typedef enum logic [1:0] {
        STEP_C_TO_D,
        STEP_D_TO_Z,
        STEP_Z_TO_C
    } mpsc_step_t;

endpackage : mpsc_pkg

// *** rtl/mpsc_pwm_chan.sv ***
// One edge-aligned PWM compare channel.
// Assumes the counter and period come from the same clock domain.
`timescale 1ns/1ps
module mpsc_pwm_chan
    import mpsc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [CNT_W-1:0] cnt,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic [CMP_W-1:0] cmp,
    output logic                  pwm
);

    logic             pwm_reg;
    logic             pwm_next;
    logic [CMP_W-1:0] ext_period;
    logic [CMP_W-1:0] ext_cnt;
    logic             hold_high;
    logic             hold_low;

    // =======================================================
    // Compare decode
    assign ext_period = {1'b0, period};
    assign ext_cnt    = {1'b0, cnt};
    assign hold_high  = (cmp > ext_period);
    assign hold_low   = (cmp == {CMP_W{1'b0}});

    // Set at counter clear, drop on compare match
    assign pwm_next = hold_low  ? 1'b0 :
                      hold_high ? 1'b1 :
                      (ext_cnt == cmp) ? 1'b0 :
                      (cnt == {CNT_W{1'b0}}) ? 1'b1 :
                      pwm_reg;

    // Output flop
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pwm_reg <= 1'b0;
        else
            pwm_reg <= pwm_next;
    end

    assign pwm = pwm_reg;

endmodule : mpsc_pwm_chan

// *** rtl/mpsc_top.sv ***
// Motor PWM counter, compare outputs, control register B and step sequencing.
// Assumes comparator and current limit pins are asynchronous; event strobes are on sys_clk.
`timescale 1ns/1ps
// What this block does
// - The PWM counter counts up to the 12-bit period, then clears to zero and counts up again.
// - Each PWM output drops to 0 when the counter reaches its compare value and rises to 1 when the counter clears.
// - A compare value above the 13-bit extended period holds that output at 1.
// - A compare value of zero holds that output at 0.
// - The edge select bit picks a falling zero-crossing edge when 0 and a rising edge when 1.
// - The hardware demagnetisation enable bit gates hardware demagnetisation detection.
// - The simulated demagnetisation enable bit gates simulated demagnetisation events.
// - A set current limit flag switches the PWM off, and the interrupt fires whenever the mask is set, whatever the overcurrent bit.
// - Mask, flag and voltage-mode overcurrent bit all set clear the main output enable and fire the interrupt.
// - Three step mode bits pick high-side or low-side PWM for the C-D, D-Z and Z-C intervals.
// - Edge select, both demag enables and the C-D mode bit only take effect at the next commutation event.
// - In direct access mode every write of the phase state register makes a commutation event.
// - Control register B resets to 00h and its top bit stays zero.
// - The D event ends demagnetisation and must precede the Z event in each step, unless both demag enables are off.
module mpsc_top
    import mpsc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wr_data,
    input  wire logic              reg_wr_stb,
    input  wire logic              reg_rd_stb,
    output logic [DATA_W-1:0]      reg_rd_data,
    input  wire logic              zero_cross_cmp_in,
    input  wire logic              demag_cmp_in,
    input  wire logic              current_limit_in,
    input  wire logic              sim_demag_pulse,
    input  wire logic              comm_event_pulse,
    output logic [5:0]             motor_phase_outputs,
    output logic                   main_output_enable,
    output logic                   current_limit_irq,
    output logic [1:0]             step_interval
);

    // =======================================================
    // Declarations
    logic [CNT_W-1:0]  period_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic [CMP_W-1:0]  cmp_reg [NUM_CH];
    logic [NUM_CH-1:0] pwm_ch;
    logic [7:0]        ctrl_b_reg;
    logic [7:0]        active_b_reg;
    logic [7:0]        active_b_next;
    logic [3:0]        phase_reg;
    logic [2:0]        misc_reg;
    logic [2:0]        misc_next;
    logic              cli_reg;
    logic              cli_next;
    logic [2:0]        sync1_reg;
    logic [2:0]        sync2_reg;
    logic [2:0]        prev_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_mux;
    logic [5:0]        out_reg;
    logic [5:0]        out_next;
    logic              irq_reg;
    logic              irq_next;
    mpsc_step_t        step_reg;
    mpsc_step_t        step_next;
    logic              wr_period;
    logic              wr_ctrl_b;
    logic              wr_phase;
    logic              wr_misc;
    logic              wr_status;
    logic              c_event;
    logic              z_rise;
    logic              z_fall;
    logic              d_rise;
    logic              d_fall;
    logic              z_event;
    logic              hw_d_event;
    logic              sim_d_event;
    logic              d_event;
    logic              demag_off;
    logic              low_side_pwm;
    logic              pwm_gated;
    logic              ovc_trip;
    logic [1:0]        hi_idx;
    logic [1:0]        lo_idx;

    // =======================================================
    // Register address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    assign wr_period = reg_wr_stb && hit(reg_addr, ADDR_PERIOD);
    assign wr_ctrl_b = reg_wr_stb && hit(reg_addr, ADDR_CTRL_B);
    assign wr_phase  = reg_wr_stb && hit(reg_addr, ADDR_PHASE);
    assign wr_misc   = reg_wr_stb && hit(reg_addr, ADDR_MISC);
    assign wr_status = reg_wr_stb && hit(reg_addr, ADDR_STATUS);

    // =======================================================
    // Pin synchronisers: zero cross, demag, current limit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg  <= 3'h0;
        end
        else
        begin
            sync1_reg <= {current_limit_in, demag_cmp_in, zero_cross_cmp_in};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // =======================================================
    // Event decode
    assign c_event     = comm_event_pulse || (wr_phase && misc_reg[MISC_DIRECT]);
    assign z_rise      = sync2_reg[0] && !prev_reg[0];
    assign z_fall      = !sync2_reg[0] && prev_reg[0];
    assign d_rise      = sync2_reg[1] && !prev_reg[1];
    assign d_fall      = !sync2_reg[1] && prev_reg[1];
    // Z on selected edge, D on the opposite one
    assign z_event     = active_b_reg[CB_EDGE] ? z_rise : z_fall;
    assign hw_d_event  = active_b_reg[CB_HDM] && (active_b_reg[CB_EDGE] ? d_fall : d_rise);
    assign sim_d_event = active_b_reg[CB_SDM] && sim_demag_pulse;
    assign d_event     = hw_d_event || sim_d_event;
    // Demag choice on a C event follows the value that this event loads
    assign demag_off   = !active_b_next[CB_HDM] && !active_b_next[CB_SDM];

    // =======================================================
    // Step sequencing; Z only accepted after D, or straight after C with both demag enables off
    always_comb
    begin
        step_next = step_reg;
        if (c_event)
            step_next = demag_off ? STEP_D_TO_Z : STEP_C_TO_D;
        else
        begin
            case (step_reg)
                STEP_C_TO_D: if (d_event) step_next = STEP_D_TO_Z;
                STEP_D_TO_Z: if (z_event) step_next = STEP_Z_TO_C;
                STEP_Z_TO_C: step_next = STEP_Z_TO_C;
                default:     step_next = STEP_C_TO_D;
            endcase
        end
    end

    // =======================================================
    // Control register B: preload bits move on C event, others direct
    assign active_b_next = c_event ? ctrl_b_reg :
                           ((active_b_reg & CB_PRELOAD) | (ctrl_b_reg & ~CB_PRELOAD));

    // Current limit flag and overcurrent trip; set wins over clear
    assign cli_next  = sync2_reg[2] || (cli_reg && !(wr_status && reg_wr_data[ST_CLI]));
    assign ovc_trip  = misc_reg[MISC_CURRENT_LIMIT_IRQ_MASK] && cli_reg && active_b_reg[CB_OCV];
    assign irq_next  = misc_reg[MISC_CURRENT_LIMIT_IRQ_MASK] && cli_reg;
    assign misc_next = {(wr_misc ? reg_wr_data[MISC_MOE] : misc_reg[MISC_MOE]) && !ovc_trip,
                        wr_misc ? reg_wr_data[MISC_CURRENT_LIMIT_IRQ_MASK:MISC_DIRECT] : misc_reg[MISC_CURRENT_LIMIT_IRQ_MASK:MISC_DIRECT]};

    // =======================================================
    // Control and status registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            period_reg   <= {CNT_W{1'b0}};
            ctrl_b_reg   <= CB_RESET;
            active_b_reg <= CB_RESET;
            phase_reg    <= PHASE_RESET;
            misc_reg     <= MISC_RESET;
            cli_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            step_reg     <= STEP_C_TO_D;
        end
        else
        begin
            if (wr_period)
                period_reg <= reg_wr_data[CNT_W-1:0];
            if (wr_ctrl_b)
                ctrl_b_reg <= reg_wr_data[7:0] & CB_WR_MASK;
            if (wr_phase)
                phase_reg <= reg_wr_data[3:0];
            active_b_reg <= active_b_next;
            misc_reg     <= misc_next;
            cli_reg      <= cli_next;
            irq_reg      <= irq_next;
            step_reg     <= step_next;
        end
    end

    // =======================================================
    // Channel compare registers
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    cmp_reg[g] <= {CMP_W{1'b0}};
                else if (reg_wr_stb && hit(reg_addr, ADDR_CMP0 + 4'(g)))
                    cmp_reg[g] <= reg_wr_data[CMP_W-1:0];
            end

            mpsc_pwm_chan u_chan (
                .sys_clk (sys_clk),
                .rst     (rst),
                .cnt     (cnt_reg),
                .period  (period_reg),
                .cmp     (cmp_reg[g]),
                .pwm     (pwm_ch[g])
            );
        end
    endgenerate

    // =======================================================
    // Edge-aligned PWM counter
    assign cnt_next = (cnt_reg >= period_reg) ? {CNT_W{1'b0}} : cnt_reg + 12'h001;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cnt_reg <= {CNT_W{1'b0}};
        else
            cnt_reg <= cnt_next;
    end

    // =======================================================
    // Output steering: PWM on high or low switch of the active pair
    assign hi_idx       = (phase_reg[1:0] > 2'h2) ? 2'h2 : phase_reg[1:0];
    assign lo_idx       = (phase_reg[3:2] > 2'h2) ? 2'h2 : phase_reg[3:2];
    assign low_side_pwm = (step_reg == STEP_C_TO_D) ? active_b_reg[CB_OS_CD] :
                          (step_reg == STEP_D_TO_Z) ? active_b_reg[CB_OS_DZ] :
                                                      active_b_reg[CB_OS_ZC];
    assign pwm_gated    = pwm_ch[hi_idx] && !cli_reg;

    always_comb
    begin
        out_next = 6'h00;
        if (misc_reg[MISC_MOE])
        begin
            out_next[hi_idx]     = low_side_pwm ? 1'b1 : pwm_gated;
            out_next[3 + lo_idx] = low_side_pwm ? pwm_gated : 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            out_reg <= 6'h00;
        else
            out_reg <= out_next;
    end

    // =======================================================
    // Read path; unmapped words read zero
    always_comb
    begin
        rd_mux = {DATA_W{1'b0}};
        case (reg_addr)
            ADDR_PERIOD:   rd_mux = {4'h0, period_reg};
            4'h1:          rd_mux = {3'h0, cmp_reg[0]};
            4'h2:          rd_mux = {3'h0, cmp_reg[1]};
            4'h3:          rd_mux = {3'h0, cmp_reg[2]};
            ADDR_CTRL_B:   rd_mux = {8'h00, ctrl_b_reg};
            ADDR_PHASE:    rd_mux = {12'h000, phase_reg};
            ADDR_MISC:     rd_mux = {13'h0000, misc_reg};
            ADDR_STATUS:   rd_mux = {13'h0000, step_reg, cli_reg};
            default:       rd_mux = {DATA_W{1'b0}};
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rd_data_reg <= {DATA_W{1'b0}};
        else if (reg_rd_stb)
            rd_data_reg <= rd_mux;
        else
            rd_data_reg <= {DATA_W{1'b0}};
    end

    // Output assignments, all from flops
    assign reg_rd_data         = rd_data_reg;
    assign motor_phase_outputs = out_reg;
    assign main_output_enable  = misc_reg[MISC_MOE];
    assign current_limit_irq   = irq_reg;
    assign step_interval       = step_reg;

    // =======================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    cnt_wrap_a: assert property (cnt_reg >= period_reg |=> cnt_reg == 12'h000)
        else $error("counter did not clear at period");
    cnt_step_a: assert property (cnt_reg < period_reg |=> cnt_reg == $past(cnt_reg) + 12'h001)
        else $error("counter did not count up");
    pwm_drop_a: assert property ((cmp_reg[0] != 13'h0000) && (cmp_reg[0] <= {1'b0, period_reg})
        && ({1'b0, cnt_reg} == cmp_reg[0]) |=> !pwm_ch[0])
        else $error("pwm did not drop at compare");
    pwm_hold_hi_a: assert property (cmp_reg[0] > {1'b0, period_reg} |=> pwm_ch[0])
        else $error("pwm not held high above period");
    pwm_hold_lo_a: assert property (cmp_reg[0] == 13'h0000 |=> !pwm_ch[0])
        else $error("pwm not held low at zero compare");
    z_edge_a: assert property (z_event |-> (active_b_reg[CB_EDGE] ? sync2_reg[0] : !sync2_reg[0]))
        else $error("zero cross on wrong edge");
    hw_demag_gate_a: assert property (!active_b_reg[CB_HDM] |-> !hw_d_event)
        else $error("hw demag event while disabled");
    sim_demag_gate_a: assert property (!active_b_reg[CB_SDM] |-> !sim_d_event)
        else $error("sim demag event while disabled");
    cli_pwm_off_a: assert property (cli_reg && misc_reg[MISC_MOE] && !low_side_pwm |=> !out_reg[$past(hi_idx)])
        else $error("pwm not off under current limit");
    ovc_moe_a: assert property (ovc_trip |=> !misc_reg[MISC_MOE] ##1 irq_reg)
        else $error("overcurrent did not clear output enable");
    preload_hold_a: assert property (!c_event |=> (active_b_reg & CB_PRELOAD) == $past(active_b_reg & CB_PRELOAD))
        else $error("preload bits moved without commutation");
    direct_comm_a: assert property (wr_phase && misc_reg[MISC_DIRECT] |=> step_reg != STEP_Z_TO_C)
        else $error("phase write did not commutate");
    reserved_bit_a: assert property (!ctrl_b_reg[7])
        else $error("reserved bit of control register set");
    z_after_d_a: assert property (step_reg == STEP_C_TO_D && !d_event && !c_event |=> step_reg == STEP_C_TO_D)
        else $error("step left C-D without D event");

    // Further checks on PWM rise, flag, output and step logic
    pwm_rise_a: assert property ((cnt_reg == 12'h000) && (cmp_reg[0] != 13'h0000) |=> pwm_ch[0])
        else $error("pwm did not rise at counter clear");
    irq_level_a: assert property (misc_reg[MISC_CURRENT_LIMIT_IRQ_MASK] && cli_reg |=> irq_reg)
        else $error("interrupt missing with mask and flag");
    moe_off_a: assert property (!misc_reg[MISC_MOE] |=> out_reg == 6'h00)
        else $error("switch drive without output enable");
    low_side_a: assert property (misc_reg[MISC_MOE] && low_side_pwm |=> out_reg[$past(hi_idx)])
        else $error("high switch not held on in low side mode");
    d_advance_a: assert property (step_reg == STEP_C_TO_D && d_event && !c_event |=> step_reg == STEP_D_TO_Z)
        else $error("D event did not advance step");
    comm_restart_a: assert property (c_event && !demag_off |=> step_reg == STEP_C_TO_D)
        else $error("C event did not restart step");
    cb_load_a: assert property (c_event |=> active_b_reg == $past(ctrl_b_reg))
        else $error("C event did not load control bits");

endmodule : mpsc_top

// *** dv/mpsc_bridge_model.sv ***
// Behavioural model of the three-phase power bridge and its current sense.
// Assumes switch drives are high = on and the bench commands an overload.
`timescale 1ns/1ps
module mpsc_bridge_model
(
    input  wire logic [5:0] motor_phase_outputs,
    input  wire logic       overload_cmd,
    output logic            current_limit_in,
    output logic            shoot_through
);
    // ==========================================================
    // Current sense
    // Current flows only while some switch conducts into the overload
    assign current_limit_in = overload_cmd & (|motor_phase_outputs);
    // High and low switch of one leg on together shorts the supply; no dead time is added
    assign shoot_through    = |(motor_phase_outputs[2:0] & motor_phase_outputs[5:3]);
endmodule : mpsc_bridge_model

// *** dv/motor_pwm_step_control_test.sv ***
// Self-checking bench for the motor PWM and step control block.
// Assumes the bridge model drives the current sense and the bench owns the bus.
`timescale 1ns/1ps
module motor_pwm_step_control_test;
    import mpsc_pkg::*;
    logic              sys_clk     = 1'b0;
    logic              rst         = 1'b1;
    logic [ADDR_W-1:0] reg_addr    = 4'h0;
    logic [DATA_W-1:0] reg_wr_data = 16'h0000;
    logic              reg_wr_stb  = 1'b0;
    logic              reg_rd_stb  = 1'b0;
    logic [DATA_W-1:0] reg_rd_data;
    logic              zc_in       = 1'b1;
    logic              dm_in       = 1'b0;
    logic              cur_in;
    logic              sim_pulse   = 1'b0;
    logic              comm_pulse  = 1'b0;
    logic [5:0]        motor_phase_outputs;
    logic              main_output_enable;
    logic              current_limit_irq;
    logic [1:0]        step_interval;
    logic              overload    = 1'b0;
    logic              short_seen;
    int                num_errors  = 0;
    int                cmp_count   = 0;
    int                hi;
    logic [15:0]       rd;
    typedef struct { logic [15:0] per; logic [15:0] cmp; int hi; } mpsc_row_t;
    mpsc_row_t         rows [7];

    // ==========================================================
    // Clock, design and bridge
    always #25 sys_clk = ~sys_clk;
    mpsc_top dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
        .zero_cross_cmp_in(zc_in), .demag_cmp_in(dm_in), .current_limit_in(cur_in),
        .sim_demag_pulse(sim_pulse), .comm_event_pulse(comm_pulse),
        .motor_phase_outputs(motor_phase_outputs), .main_output_enable(main_output_enable),
        .current_limit_irq(current_limit_irq), .step_interval(step_interval));
    mpsc_bridge_model bridge_u (.motor_phase_outputs(motor_phase_outputs), .overload_cmd(overload),
        .current_limit_in(cur_in), .shoot_through(short_seen));

    // ==========================================================
    // Bus, event and compare tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_stb  <= 1'b1;
        @(posedge sys_clk);
        reg_wr_stb  <= 1'b0;
    endtask : wr
    task rdreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr   <= a;
        reg_rd_stb <= 1'b1;
        @(posedge sys_clk);
        reg_rd_stb <= 1'b0;
        #1 d = reg_rd_data;
    endtask : rdreg
    // Pulse commutation (k=0) or simulated demag (k=1), then let it settle
    task ev(input int k);
        @(posedge sys_clk);
        if (k == 0) comm_pulse <= 1'b1;
        else sim_pulse <= 1'b1;
        @(posedge sys_clk);
        comm_pulse <= 1'b0;
        sim_pulse  <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : ev
    task pins(input logic z, input logic d);
        @(posedge sys_clk);
        zc_in <= z;
        dm_in <= d;
        repeat (8) @(posedge sys_clk);
    endtask : pins
    // Count high cycles of one switch drive over n clocks
    task duty(input int idx, input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge sys_clk);
            if (motor_phase_outputs[idx] === 1'b1) h++;
        end
    endtask : duty
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Shoot-through watch over the whole run
    always @(posedge sys_clk) if (short_seen === 1'b1) chk(16'h1, 16'h0, "bridge leg shorted");

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rows = '{'{16'h3, 16'h2, 2}, '{16'h3, 16'h0, 0}, '{16'h3, 16'h3, 3}, '{16'h3, 16'h4, 4},
                 '{16'h7, 16'h1, 1}, '{16'h7, 16'h1000, 8}, '{16'h7, 16'h3, 3}};
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rdreg(ADDR_CTRL_B, rd); chk(rd, 16'h0000, "ctrl B reset");
        chk({14'h0, step_interval}, 16'h0, "step after reset");
        wr(ADDR_CTRL_B, 16'h00ff);
        rdreg(ADDR_CTRL_B, rd); chk(rd, 16'h007f, "ctrl B reserved bit");
        rdreg(4'hf, rd); chk(rd, 16'h0000, "unmapped read");
        wr(ADDR_CTRL_B, 16'h0000);
        wr(ADDR_MISC, 16'h0004);
        $display("test registers done");
        // Table of period, compare and high cycles per PWM period
        foreach (rows[i])
        begin
            wr(ADDR_PERIOD, rows[i].per);
            wr(ADDR_CMP0, rows[i].cmp);
            repeat (20) @(posedge sys_clk);
            duty(0, 4 * (rows[i].per + 1), hi);
            chk(16'(hi), 16'(4 * rows[i].hi), "duty row");
        end
        $display("test pwm table done");
        // Top mode bit is preloaded; C event swaps PWM to the low switch
        wr(ADDR_CTRL_B, 16'h0014);
        repeat (4) @(posedge sys_clk);
        duty(0, 32, hi); chk(16'(hi), 16'd12, "high side before C");
        ev(0);
        duty(4, 32, hi); chk(16'(hi), 16'd12, "low side after C");
        duty(0, 32, hi); chk(16'(hi), 16'd32, "high switch held on");
        wr(ADDR_CTRL_B, 16'h0010);
        wr(ADDR_MISC, 16'h0005);
        wr(ADDR_PHASE, 16'h0004);
        repeat (8) @(posedge sys_clk);
        duty(0, 32, hi); chk(16'(hi), 16'd12, "direct write is C");
        chk({14'h0, step_interval}, 16'h0, "step C-D after C");
        wr(ADDR_MISC, 16'h0004);
        $display("test preload done");
        // Step sequence: hw demag on, falling zero crossing
        wr(ADDR_CTRL_B, 16'h0030);
        ev(0);
        pins(1'b0, 1'b0); chk({14'h0, step_interval}, 16'h0, "Z before D ignored");
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1); chk({14'h0, step_interval}, 16'h1, "hw D event");
        pins(1'b0, 1'b1); chk({14'h0, step_interval}, 16'h2, "falling Z");
        // Hw demag off, simulated on; edge select pending
        wr(ADDR_CTRL_B, 16'h0010);
        ev(0);
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1); chk({14'h0, step_interval}, 16'h0, "hw D masked");
        ev(1); chk({14'h0, step_interval}, 16'h1, "sim D event");
        wr(ADDR_CTRL_B, 16'h0050);
        pins(1'b1, 1'b1); chk({14'h0, step_interval}, 16'h1, "edge select pending");
        ev(0);
        ev(1);
        pins(1'b0, 1'b1); chk({14'h0, step_interval}, 16'h1, "falling Z ignored");
        pins(1'b1, 1'b1); chk({14'h0, step_interval}, 16'h2, "rising Z");
        $display("test steps done");
        // Current limit, protection off: PWM off and interrupt
        wr(ADDR_CTRL_B, 16'h0010);
        ev(0);
        wr(ADDR_MISC, 16'h0006);
        overload <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk({15'h0, current_limit_irq}, 16'h1, "irq with mask");
        chk({15'h0, main_output_enable}, 16'h1, "enable kept");
        duty(0, 32, hi); chk(16'(hi), 16'd0, "PWM forced off");
        rdreg(ADDR_STATUS, rd); chk(rd & 16'h1, 16'h1, "flag set");
        overload <= 1'b0;
        repeat (4) @(posedge sys_clk); // Let the sense drop through the synchroniser first
        wr(ADDR_STATUS, 16'h0001);
        repeat (4) @(posedge sys_clk);
        chk({15'h0, current_limit_irq}, 16'h0, "irq cleared");
        // Protection on: enable drops, all switches off
        wr(ADDR_CTRL_B, 16'h0018);
        repeat (4) @(posedge sys_clk);
        overload <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk({15'h0, main_output_enable}, 16'h0, "enable cleared");
        chk({10'h0, motor_phase_outputs}, 16'h0, "outputs off");
        chk({15'h0, current_limit_irq}, 16'h1, "irq on trip");
        rdreg(ADDR_MISC, rd); chk(rd, 16'h0002, "misc after trip");
        $display("test current limit done");
        wrap_up();
    end
endmodule : motor_pwm_step_control_test
